//--- rtl/pei_pkg.sv
// package: register map, field positions and reset values of the event interrupt unit
package pei_pkg;
   localparam int          DATA_W          = 16;
   // printed offsets are not all multiples of four: these are indices, byte address = 4 * index
   localparam logic [7:0]  IDX_ENABLE      = 8'h12;
   localparam logic [7:0]  IDX_STATUS      = 8'h13;
   localparam logic [7:0]  IDX_CONFIG      = 8'h14;
   localparam logic [11:0] ADDR_ENABLE     = 12'({IDX_ENABLE, 2'b00});
   localparam logic [11:0] ADDR_STATUS     = 12'({IDX_STATUS, 2'b00});
   localparam logic [11:0] ADDR_CONFIG     = 12'({IDX_CONFIG, 2'b00});
   localparam logic [15:0] ENABLE_RESET    = 16'h0000;
   localparam logic [15:0] STATUS_RESET    = 16'h0000;
   localparam int          POLARITY_BIT    = 13;
   localparam logic        POLARITY_RESET  = 1'b1;
   // status bits that clear on a read of the status register
   localparam logic [15:0] CLEAR_ON_READ   = 16'hfdf1;
   // status bits that follow a live level rather than latching
   localparam logic [15:0] LIVE_LEVEL      = 16'h020c;
   localparam int          BIT_NEG_FAULT   = 15;
   localparam int          BIT_RATE        = 14;
   localparam int          BIT_DUPLEX      = 13;
   localparam int          BIT_PAGE        = 12;
   localparam int          BIT_NEG_DONE    = 11;
   localparam int          BIT_LINK        = 10;
   localparam int          BIT_EEE         = 9;
   localparam int          BIT_CARRIER     = 8;
   localparam int          BIT_CONVERTER   = 7;
   localparam int          BIT_PAIR_SWAP   = 6;
   localparam int          BIT_DOWNSHIFT   = 5;
   localparam int          BIT_DOZE        = 4;
   localparam int          BIT_WAKE        = 3;
   localparam int          BIT_MAC_BUF     = 2;
   localparam int          BIT_INVERSION   = 1;
   localparam int          BIT_JABBER      = 0;
endpackage

//--- rtl/pei_event_unit.sv
// event interrupt unit: enable and latched status registers behind an apb slave
//
// Function
// - enabled event that occurs raises interrupt
// - enable register resets zero, bits match status
// - latched status bit set if event since read
// - status records even when event disabled
// - status register sixteen bits, resets zero
// - bit 15 negotiation fault, clear on read
// - bit 14 rate change, clear on read
// - bit 13 duplex change, clear on read
// - bit 12 page received, clear on read
// - bit 11 negotiation done, clear on read
// - bit 10 link change, clear on read
// - bit 9 energy efficient fault, read only
// - bit 8 bogus carrier, clear on read
// - bit 7 converter buffer fault, clear read
// - bits 6,5 pair swap, downshift, clear read
// - bit 4 doze change, clear on read
// - bit 3 wake packet, read only
// - bit 2 mac buffer fault, read only
// - bit 1 inversion change latches high
// - bit 0 jabber, clear on read
// - polarity bit resets one, one active low
`timescale 1ns/1ns
`default_nettype none
module pei_event_unit
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        negotiation_fault_flag,
   input  wire logic        rate_changed_flag,
   input  wire logic        duplex_changed_flag,
   input  wire logic        page_received_flag,
   input  wire logic        negotiation_done_flag,
   input  wire logic        link_changed_flag,
   input  wire logic        energy_efficient_fault_flag,
   input  wire logic        bogus_carrier_flag,
   input  wire logic        converter_buffer_fault_flag,
   input  wire logic        pair_swap_changed_flag,
   input  wire logic        rate_downshift_flag,
   input  wire logic        doze_changed_flag,
   input  wire logic        wake_packet_flag,
   input  wire logic        mac_buffer_fault_flag,
   input  wire logic        line_inversion_changed_flag,
   input  wire logic        jabber_flag,
   output logic             event_irq_pin
);

   // whole module state in one record
   typedef struct packed
   {
      logic [15:0] enable;
      logic [15:0] status;
      logic        polarity_low;
      logic [31:0] rdata;
      logic        ready;
      logic        slverr;
      logic        irq_pin;
   } pei_state_t;

   pei_state_t state_r;
   pei_state_t state_nxt;
   logic [15:0] event_vec;
   logic        access;
   logic        setup;

   // address decode, used for both reads and writes
   function automatic logic [1:0] pei_decode(input logic [11:0] addr);
      if (addr == pei_pkg::ADDR_ENABLE)
         pei_decode = 2'h1;
      else if (addr == pei_pkg::ADDR_STATUS)
         pei_decode = 2'h2;
      else if (addr == pei_pkg::ADDR_CONFIG)
         pei_decode = 2'h3;
      else
         pei_decode = 2'h0;
   endfunction

   // merge byte lanes of a write into a 16-bit register
   function automatic logic [15:0] pei_merge(input logic [15:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  strb);
      pei_merge = old;
      if (strb[0])
         pei_merge[7:0] = wd[7:0];
      if (strb[1])
         pei_merge[15:8] = wd[15:8];
   endfunction

   // gather event inputs into status bit order
   always_comb
   begin
      event_vec = '0;
      event_vec[pei_pkg::BIT_NEG_FAULT] = negotiation_fault_flag;
      event_vec[pei_pkg::BIT_RATE]      = rate_changed_flag;
      event_vec[pei_pkg::BIT_DUPLEX]    = duplex_changed_flag;
      event_vec[pei_pkg::BIT_PAGE]      = page_received_flag;
      event_vec[pei_pkg::BIT_NEG_DONE]  = negotiation_done_flag;
      event_vec[pei_pkg::BIT_LINK]      = link_changed_flag;
      event_vec[pei_pkg::BIT_EEE]       = energy_efficient_fault_flag;
      event_vec[pei_pkg::BIT_CARRIER]   = bogus_carrier_flag;
      event_vec[pei_pkg::BIT_CONVERTER] = converter_buffer_fault_flag;
      event_vec[pei_pkg::BIT_PAIR_SWAP] = pair_swap_changed_flag;
      event_vec[pei_pkg::BIT_DOWNSHIFT] = rate_downshift_flag;
      event_vec[pei_pkg::BIT_DOZE]      = doze_changed_flag;
      event_vec[pei_pkg::BIT_WAKE]      = wake_packet_flag;
      event_vec[pei_pkg::BIT_MAC_BUF]   = mac_buffer_fault_flag;
      event_vec[pei_pkg::BIT_INVERSION] = line_inversion_changed_flag;
      event_vec[pei_pkg::BIT_JABBER]    = jabber_flag;
   end

   assign setup  = psel & ~penable;
   assign access = psel & penable & state_r.ready;

   // next state: bus slave, status latching, interrupt pin
   always_comb
   begin
      logic        any_irq;
      logic [15:0] cleared;
      any_irq   = 1'b0;
      cleared   = state_r.status;
      state_nxt = state_r;
      state_nxt.ready  = 1'b0;
      state_nxt.slverr = 1'b0;
      // answer one cycle after setup, read data captured at setup
      if (setup)
      begin
         state_nxt.ready = 1'b1;
         state_nxt.rdata = '0;
         case (pei_decode(paddr))
            2'h1:    state_nxt.rdata[15:0] = state_r.enable;
            2'h2:    state_nxt.rdata[15:0] = state_r.status;
            2'h3:    state_nxt.rdata[pei_pkg::POLARITY_BIT] = state_r.polarity_low;
            default: state_nxt.slverr = 1'b1;
         endcase
      end
      // completed access: writes land, status read clears
      if (access)
      begin
         if (pwrite)
         begin
            case (pei_decode(paddr))
               2'h1:    state_nxt.enable = pei_merge(state_r.enable, pwdata, pstrb);
               2'h3:
               begin
                  if (pstrb[1])
                     state_nxt.polarity_low = pwdata[pei_pkg::POLARITY_BIT];
               end
               default: state_nxt.enable = state_r.enable;
            endcase
         end
         else if (pei_decode(paddr) == 2'h2)
            cleared = state_r.status & ~pei_pkg::CLEAR_ON_READ;
      end
      // live bits track their source; latched bits set, set beats clear
      state_nxt.status = (cleared & ~pei_pkg::LIVE_LEVEL)
                       | (event_vec & ~pei_pkg::LIVE_LEVEL)
                       | (event_vec & pei_pkg::LIVE_LEVEL);
      // interrupt from enabled status, live and latched bits
      any_irq = |(state_nxt.status & state_r.enable);
      state_nxt.irq_pin = state_r.polarity_low ? ~any_irq : any_irq;
   end

   // state register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r.enable       <= pei_pkg::ENABLE_RESET;
         state_r.status       <= pei_pkg::STATUS_RESET;
         state_r.polarity_low <= pei_pkg::POLARITY_RESET;
         state_r.rdata        <= '0;
         state_r.ready        <= 1'b0;
         state_r.slverr       <= 1'b0;
         state_r.irq_pin      <= pei_pkg::POLARITY_RESET;
      end
      else
         state_r <= state_nxt;
   end

   assign prdata        = state_r.rdata;
   assign pready        = state_r.ready;
   assign pslverr       = state_r.slverr;
   assign event_irq_pin = state_r.irq_pin;

endmodule
`default_nettype wire

//--- testbench/pei_event_chk.sv
// checker: apb timing and interrupt pin of the event unit
`timescale 1ns/1ns
`default_nettype none
module pei_event_chk
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        event_irq_pin
);
   logic map_w;
   // address hits one of the three registers
   assign map_w = paddr == pei_pkg::ADDR_ENABLE || paddr == pei_pkg::ADDR_STATUS
                  || paddr == pei_pkg::ADDR_CONFIG;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   ready_access_a: assert property (pready |-> psel && penable)
      else $error("ready outside access phase");
   unmapped_err_a: assert property (psel && !penable && !map_w |=> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   mapped_ok_a: assert property (pready && map_w |-> !pslverr)
      else $error("error on mapped register");
   upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0)
      else $error("read data above bit 15");
   rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
      else $error("read data moved outside setup");
   irq_idle_reset_a: assert property ($rose(presetn) |-> event_irq_pin)
      else $error("pin active after reset");
endmodule
bind pei_event_unit pei_event_chk i_chk (.pclk, .presetn, .psel, .penable, .paddr, .prdata,
   .pready, .pslverr, .event_irq_pin);
`default_nettype wire

//--- testbench/phy_event_interrupt_unit_test.sv
// testbench: register access, event latching and interrupt pin
`timescale 1ns/1ns
`default_nettype none
module phy_event_interrupt_unit_test;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, irq, rdy, err, e;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic [15:0] ev = 16'h0;
   logic [3:0] pstrb = 4'hf;
   int n_errors = 0, n_checks = 0, cyc = 0;
   always #5 pclk = ~pclk;
   pei_event_unit i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready(rdy), .pslverr(err), .event_irq_pin(irq),
      .negotiation_fault_flag(ev[15]), .rate_changed_flag(ev[14]),
      .duplex_changed_flag(ev[13]), .page_received_flag(ev[12]),
      .negotiation_done_flag(ev[11]), .link_changed_flag(ev[10]),
      .energy_efficient_fault_flag(ev[9]), .bogus_carrier_flag(ev[8]),
      .converter_buffer_fault_flag(ev[7]), .pair_swap_changed_flag(ev[6]),
      .rate_downshift_flag(ev[5]), .doze_changed_flag(ev[4]), .wake_packet_flag(ev[3]),
      .mac_buffer_fault_flag(ev[2]), .line_inversion_changed_flag(ev[1]),
      .jabber_flag(ev[0]));
   task automatic test_done;
      if (n_errors == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // cut a hang short
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_errors++;
         test_done;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer, idle edge after it
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (rdy !== 1'b1) @(posedge pclk);
      r = prdata;
      e = err;
      psel <= 0; penable <= 0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(r, exp);
   endtask
   // event pulse one cycle, pin settled after
   task automatic pulse(input logic [15:0] m);
      ev <= m;
      @(posedge pclk);
      ev <= 16'h0;
      repeat (2) @(posedge pclk);
   endtask
   task automatic t_reset;
      rd(pei_pkg::ADDR_ENABLE, 32'h0);
      rd(pei_pkg::ADDR_STATUS, 32'h0);
      rd(pei_pkg::ADDR_CONFIG, 32'h2000);
      chk(irq, 1'b1);
      xfer(1'b0, 12'h040, 32'h0);
      chk(e, 1'b1);
   endtask
   task automatic t_masked;
      pulse(16'h0001);
      chk(irq, 1'b1);
      rd(pei_pkg::ADDR_STATUS, 32'h1);
      rd(pei_pkg::ADDR_STATUS, 32'h0);
   endtask
   task automatic t_events;
      for (int i = 0; i < 16; i++)
         if (pei_pkg::CLEAR_ON_READ[i])
         begin
            xfer(1'b1, pei_pkg::ADDR_ENABLE, 32'h1 << i);
            pulse(16'h1 << i);
            chk(irq, 1'b0);
            rd(pei_pkg::ADDR_STATUS, 32'h1 << i);
            @(posedge pclk);
            chk(irq, 1'b1);
            rd(pei_pkg::ADDR_STATUS, 32'h0);
         end
      rd(pei_pkg::ADDR_ENABLE, 32'h8000);
   endtask
   task automatic t_live;
      pulse(16'h0002);
      ev <= 16'h020c;
      repeat (2) @(posedge pclk);
      rd(pei_pkg::ADDR_STATUS, 32'h020e);
      rd(pei_pkg::ADDR_STATUS, 32'h020e);
      ev <= 16'h0;
      repeat (2) @(posedge pclk);
      rd(pei_pkg::ADDR_STATUS, 32'h0002);
   endtask
   task automatic t_polarity;
      xfer(1'b1, pei_pkg::ADDR_CONFIG, 32'h0);
      xfer(1'b1, pei_pkg::ADDR_ENABLE, 32'h1);
      pulse(16'h0001);
      chk(irq, 1'b1);
      rd(pei_pkg::ADDR_STATUS, 32'h0003);
      @(posedge pclk);
      chk(irq, 1'b0);
   endtask
   // byte lanes: only strobed lanes land
   task automatic t_strobe;
      pstrb <= 4'h1;
      xfer(1'b1, pei_pkg::ADDR_ENABLE, 32'h0000ffff);
      rd(pei_pkg::ADDR_ENABLE, 32'h00ff);
      xfer(1'b1, pei_pkg::ADDR_CONFIG, 32'h2000);
      rd(pei_pkg::ADDR_CONFIG, 32'h0);
      pstrb <= 4'hf;
      xfer(1'b1, pei_pkg::ADDR_ENABLE, 32'h0);
      rd(pei_pkg::ADDR_ENABLE, 32'h0);
   endtask
   // main sequence
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      t_reset;
      t_masked;
      t_events;
      t_live;
      t_polarity;
      t_strobe;
      test_done;
   end
endmodule
`default_nettype wire
